// file: hw/dds_top.sv
// file: serial control link, status word and fault flag logic of the twelve-switch driver
`timescale 1ns/1ps
module dds_top #(
    parameter int CUTOFF_DEAD_CYC = dds_pkg::CUTOFF_DEAD_CYC,
    parameter int BLANK_CYC       = dds_pkg::BLANK_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CHIP_SELECT_N,
    input  wire logic        SERIAL_CLK,
    input  wire logic        SERIAL_IN,
    output logic             SERIAL_OUT,
    output logic             SERIAL_OUT_EN,
    input  wire logic        STANDBY_DISABLE_INPUT_N,
    input  wire logic        LOGIC_SUPPLY_OK,
    input  wire logic        TEMP_WARN_HI,
    input  wire logic        TEMP_WARN_LO,
    input  wire logic        TEMP_SHUTDOWN,
    input  wire logic        SUPPLY_OVERVOLT,
    input  wire logic        SUPPLY_UNDERVOLT,
    input  wire logic [11:0] OVERCURRENT,
    input  wire logic [11:0] UNDERLOAD,
    input  wire logic [11:0] GATE_SENSE,
    output logic      [11:0] SWITCH_ON,
    output logic      [15:0] CONTROL_WORD,
    output logic      [15:0] DIAGNOSTIC_STATUS_WORD
);
    localparam int NSW = dds_pkg::NUM_SW;
    localparam int NS  = 10 + 3 * NSW;
    // idle levels after reset: select, inhibit and supply high, so no false edge follows reset
    localparam logic [NS-1:0] SYNC_INIT = {1'b1, 2'b00, 2'b11, {(NS-5){1'b0}}};

    // every asynchronous input passes two flops first
    logic [NS-1:0] raw_in;
    logic [NS-1:0] syn;
    assign raw_in = {CHIP_SELECT_N, SERIAL_CLK, SERIAL_IN, STANDBY_DISABLE_INPUT_N, LOGIC_SUPPLY_OK,
                     TEMP_WARN_HI, TEMP_WARN_LO, TEMP_SHUTDOWN, SUPPLY_OVERVOLT, SUPPLY_UNDERVOLT,
                     OVERCURRENT, UNDERLOAD, GATE_SENSE};
    dds_sync #(.W(NS), .INIT(SYNC_INIT)) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (raw_in),
        .q   (syn)
    );
    logic            cs_n_s, sck_s, sdi_s, inh_n_s, vcc_s, t_hi_s, t_lo_s, t_sd_s, ov_s, uv_s;
    logic [NSW-1:0]  oc_s, ul_s, gate_s;
    assign {cs_n_s, sck_s, sdi_s, inh_n_s, vcc_s, t_hi_s, t_lo_s, t_sd_s, ov_s, uv_s,
            oc_s, ul_s, gate_s} = syn;

    // edge history, one more flop behind the synchroniser
    logic cs_n_q, sck_q, vcc_q;
    logic cs_fall, cs_rise, sck_rise, sck_fall, vcc_change;
    assign cs_fall    = cs_n_q & ~cs_n_s;
    assign cs_rise    = ~cs_n_q & cs_n_s;
    assign sck_rise   = ~sck_q & sck_s & ~cs_n_s;
    assign sck_fall   = sck_q & ~sck_s & ~cs_n_s;
    assign vcc_change = vcc_q ^ vcc_s;

    // serial shifter state
    logic [15:0] shin_q, shin_d, shout_q, shout_d, ctl_q, ctl_d;
    logic        sdo_q, sdo_d, sdo_en_q, sdo_en_d;
    // status state
    logic        temp_q, temp_d, ovl_q, ovl_d, unl_q, unl_d, sup_q, sup_d;
    logic [NSW-1:0] on_q, on_d;
    logic        clear_all;
    logic        blank_busy;
    logic [NSW-1:0] cut_q, cut_d;
    logic [NSW-1:0] prev_busy_q;
    logic [NSW-1:0] ctl_sw;
    logic [NSW-1:0] oc_busy;
    logic [15:0] status_word;

    // rule 9 and 10 clear sources
    // clear on new cycle
    assign clear_all = (cs_rise & ctl_q[dds_pkg::CTL_CLEAR_BIT]) | vcc_change | ~inh_n_s;

    dds_timer #(.CYCLES(BLANK_CYC)) u_blank (
        .clk   (CLK),
        .rst   (RST),
        .start (cs_rise),
        .hold  (1'b0),
        .busy  (blank_busy)
    );

    // per-channel overcurrent dead time
    genvar g;
    generate
        for (g = 0; g < NSW; g++) begin : g_oc
            dds_timer #(.CYCLES(CUTOFF_DEAD_CYC)) u_oc (
                .clk   (CLK),
                .rst   (RST),
                .start (oc_s[g] & ~oc_busy[g] & on_q[g] & ~cut_q[g]),
                .hold  (~oc_s[g]),
                .busy  (oc_busy[g])
            );
        end
    endgenerate

    // status word assembly
    // gate sense bits
    assign status_word = {sup_q, unl_q, ovl_q, gate_s, temp_q};
    assign ctl_sw      = ctl_q[dds_pkg::CTL_SW_LSB +: NSW];

    // serial link: shift in on rising, shift out on falling
    always_comb begin
        shin_d   = shin_q;
        shout_d  = shout_q;
        ctl_d    = ctl_q;
        sdo_d    = sdo_q;
        sdo_en_d = ~cs_n_s;
        if (cs_fall) begin
            shout_d = status_word;
            sdo_d   = status_word[15];
        end else if (sck_rise) begin
            shin_d = {shin_q[14:0], sdi_s};
        end else if (sck_fall) begin
            shout_d = {shout_q[14:0], 1'b0};
            sdo_d   = shout_q[14];
        end
        if (cs_rise)
            ctl_d = shin_q;
        if (~inh_n_s)
            ctl_d = dds_pkg::CTL_RESET;
    end

    // fault flags and output drive
    always_comb begin
        temp_d = temp_q;
        if (t_hi_s)
            temp_d = 1'b1;
        else if (t_lo_s || clear_all)
            temp_d = 1'b0;
        ovl_d = (ovl_q & ~clear_all) | (|oc_s);
        unl_d = (unl_q & ~clear_all) | ((|ul_s) & ~blank_busy);
        sup_d = (sup_q & ~clear_all) | ov_s | uv_s;

        // cut after dead time
        // cut only in the cycle the timer runs out with the fault still there
        cut_d = cut_q | (oc_s & ~oc_busy & on_q & {NSW{ctl_q[dds_pkg::CTL_OC_EN_BIT]}} & prev_busy_q);
        if (!ctl_q[dds_pkg::CTL_OC_EN_BIT] || cs_rise)
            cut_d = '0;

        on_d = ctl_q[dds_pkg::CTL_SW_LSB +: NSW] & ~cut_q;
        if (t_sd_s)
            on_d = '0;
        if (ov_s && ctl_q[dds_pkg::CTL_OV_EN_BIT])
            on_d = '0;
        if (uv_s || !inh_n_s)
            on_d = '0;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cs_n_q      <= 1'b1;
            sck_q       <= 1'b0;
            vcc_q       <= 1'b1;
            shin_q      <= 16'h0000;
            shout_q     <= 16'h0000;
            ctl_q       <= dds_pkg::CTL_RESET;
            sdo_q       <= 1'b0;
            sdo_en_q    <= 1'b0;
            temp_q      <= 1'b0;
            ovl_q       <= 1'b0;
            unl_q       <= 1'b0;
            sup_q       <= 1'b0;
            on_q        <= '0;
            cut_q       <= '0;
            prev_busy_q <= '0;
        end else begin
            cs_n_q      <= cs_n_s;
            sck_q       <= sck_s;
            vcc_q       <= vcc_s;
            shin_q      <= shin_d;
            shout_q     <= shout_d;
            ctl_q       <= ctl_d;
            sdo_q       <= sdo_d;
            sdo_en_q    <= sdo_en_d;
            temp_q      <= temp_d;
            ovl_q       <= ovl_d;
            unl_q       <= unl_d;
            sup_q       <= sup_d;
            on_q        <= on_d;
            cut_q       <= cut_d;
            prev_busy_q <= oc_busy;
        end
    end

    // registered outputs
    logic [15:0] stat_out_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            stat_out_q <= dds_pkg::STATUS_RESET;
        else
            stat_out_q <= status_word;
    end
    assign SERIAL_OUT             = sdo_q;
    assign SERIAL_OUT_EN          = sdo_en_q;
    assign SWITCH_ON              = on_q;
    assign CONTROL_WORD           = ctl_q;
    assign DIAGNOSTIC_STATUS_WORD = stat_out_q;

    // checks
    property p_ovl_sticky;
        @(posedge CLK) disable iff (RST) (|oc_s) |=> ovl_q;
    endproperty
    a_ovl_sticky: assert property (p_ovl_sticky) else $error("overload flag not set");
    property p_sup;
        @(posedge CLK) disable iff (RST) (ov_s | uv_s) |=> sup_q;
    endproperty
    a_sup: assert property (p_sup) else $error("supply flag not set");
    property p_hold;
        @(posedge CLK) disable iff (RST) (ovl_q && !clear_all) |=> ovl_q;
    endproperty
    a_hold: assert property (p_hold) else $error("overload flag lost");
    property p_blank;
        @(posedge CLK) disable iff (RST) (blank_busy && !unl_q && !clear_all) |=> !unl_q;
    endproperty
    a_blank: assert property (p_blank) else $error("underload stored while blanked");
    property p_temp_set;
        @(posedge CLK) disable iff (RST) t_hi_s |=> temp_q;
    endproperty
    a_temp_set: assert property (p_temp_set) else $error("warning not set");
    property p_temp_clr;
        @(posedge CLK) disable iff (RST) (t_lo_s && !t_hi_s) |=> !temp_q;
    endproperty
    a_temp_clr: assert property (p_temp_clr) else $error("warning not cleared");
    property p_shutdown;
        @(posedge CLK) disable iff (RST) t_sd_s |=> (on_q == '0);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("outputs on during shutdown");
    property p_apply;
        @(posedge CLK) disable iff (RST) (cs_rise && inh_n_s) |=> (ctl_q == $past(shin_q));
    endproperty
    a_apply: assert property (p_apply) else $error("control word not applied");
    property p_inh;
        @(posedge CLK) disable iff (RST) !inh_n_s |=> (!ovl_q || $past(|oc_s));
    endproperty
    a_inh: assert property (p_inh) else $error("flags not cleared by inhibit");
    property p_clear_bit;
        @(posedge CLK) disable iff (RST) (cs_rise && ctl_q[dds_pkg::CTL_CLEAR_BIT] && !(|oc_s)) |=> !ovl_q;
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("flags kept after clear request");
    property p_vcc_clear;
        @(posedge CLK) disable iff (RST) (vcc_change && !(|oc_s)) |=> !ovl_q;
    endproperty
    a_vcc_clear: assert property (p_vcc_clear) else $error("flags kept after supply change");
    property p_no_cut;
        @(posedge CLK) disable iff (RST) !ctl_q[dds_pkg::CTL_OC_EN_BIT] |=> (cut_q == '0);
    endproperty
    a_no_cut: assert property (p_no_cut) else $error("channel cut while cut-off disabled");
    property p_ov_lock;
        @(posedge CLK) disable iff (RST) (ov_s && ctl_q[dds_pkg::CTL_OV_EN_BIT]) |=> (on_q == '0);
    endproperty
    a_ov_lock: assert property (p_ov_lock) else $error("outputs on during overvoltage lockout");
    property p_ov_free;
        @(posedge CLK) disable iff (RST)
            (ov_s && !ctl_q[dds_pkg::CTL_OV_EN_BIT] && !uv_s && !t_sd_s && inh_n_s)
            |=> (on_q == ($past(ctl_sw) & ~$past(cut_q)));
    endproperty
    a_ov_free: assert property (p_ov_free) else $error("outputs dropped with lockout disabled");
    property p_gate;
        @(posedge CLK) disable iff (RST)
            inh_n_s |=> (DIAGNOSTIC_STATUS_WORD[dds_pkg::ST_SW_LSB +: NSW] == $past(gate_s));
    endproperty
    a_gate: assert property (p_gate) else $error("status does not show gate state");
    property p_unl_set;
        @(posedge CLK) disable iff (RST) ((|ul_s) && !blank_busy) |=> unl_q;
    endproperty
    a_unl_set: assert property (p_unl_set) else $error("underload flag not set");
    sequence s_expired;
        (|(oc_s & ~oc_busy & on_q & prev_busy_q)) && ctl_q[dds_pkg::CTL_OC_EN_BIT] && !cs_rise;
    endsequence
    sequence s_cut_off;
        (cut_q != '0) ##1 ((on_q & $past(cut_q)) == '0);
    endsequence
    property p_cut;
        @(posedge CLK) disable iff (RST) s_expired |=> s_cut_off;
    endproperty
    a_cut: assert property (p_cut) else $error("overloaded channel not cut");
endmodule

// file: hw/dds_pkg.sv
// package: constants for the driver diagnostic status word block
package dds_pkg;
    localparam int WORD_W          = 16;
    localparam int NUM_SW          = 12;
    localparam int CLK_MHZ         = 100;
    // control word bit positions
    localparam int CTL_CLEAR_BIT   = 0;
    localparam int CTL_SW_LSB      = 1;
    localparam int CTL_OC_EN_BIT   = 13;
    localparam int CTL_OV_EN_BIT   = 15;
    // status word bit positions
    localparam int ST_TEMP_BIT     = 0;
    localparam int ST_SW_LSB       = 1;
    localparam int ST_OVL_BIT      = 13;
    localparam int ST_UNL_BIT      = 14;
    localparam int ST_SUP_BIT      = 15;
    localparam logic [15:0] CTL_RESET    = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // timing
    localparam int CUTOFF_DEAD_US  = 50;
    localparam int BLANK_US        = 300;
    localparam int CUTOFF_DEAD_CYC = CUTOFF_DEAD_US * CLK_MHZ;
    localparam int BLANK_CYC       = BLANK_US * CLK_MHZ;
endpackage

// file: hw/dds_sync.sv
// file: two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module dds_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= INIT;
            q      <= INIT;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// file: hw/dds_timer.sv
// file: retriggerable down counter, busy while counting
`timescale 1ns/1ps
module dds_timer #(
    parameter int CYCLES = 100
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic hold,
    output logic      busy
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (start)
            cnt_d = 32'(CYCLES);
        else if (hold)
            cnt_d = 32'h0000_0000;
        else if (cnt_q != 32'h0000_0000)
            cnt_d = cnt_q - 32'h0000_0001;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cnt_q <= 32'h0000_0000;
        else
            cnt_q <= cnt_d;
    end
    assign busy = (cnt_q != 32'h0000_0000);
endmodule

// file: bench/dds_host.sv
// host model: serial bus master that writes control words and reads back status
`timescale 1ns/1ps
module dds_host (
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end

    task automatic half;
        repeat (4) @(negedge clk);
    endtask

    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_n = 1'b0;
        half();
        half();
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            half();
            sck = 1'b1;
            half();
            // sampled late in the high phase: output moves only after falls
            r[i] = sdo;
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        // released data line must not look like a held bit
        sdi = ~sdi;
        repeat (12) @(negedge clk);
    endtask
endmodule

// file: bench/driver_diag_status_word_bench.sv
// self-checking bench for the status word and fault flag block
`timescale 1ns/1ps
module driver_diag_status_word_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        inh_n = 1'b1;
    logic        lsup = 1'b1;
    logic        t_hi = 1'b0;
    logic        t_lo = 1'b0;
    logic        t_sd = 1'b0;
    logic        ov = 1'b0;
    logic        uv = 1'b0;
    logic [11:0] oc = 12'h000;
    logic [11:0] ul = 12'h000;
    logic [11:0] gate = 12'h000;
    logic [11:0] sw;
    logic        cs_n, sck, sdi, sdo, sdo_en;
    logic [15:0] ctl, st, rd, w, prev;
    logic [15:0] exp_q[$];
    int          en_cycles = 0;
    // host frame: 35 half periods of 4 clocks with the select low
    localparam int FRAME_CYC = 140;
    int          mismatches = 0;
    int          tests_run = 0;
    int          m_ctl = 0;
    int          m_fl = 0;

    always #5 clk = ~clk;

    always @(negedge clk)
        if (sdo_en)
            en_cycles++;

    dds_host i_host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo));

    dds_top #(.CUTOFF_DEAD_CYC(20), .BLANK_CYC(50)) i_dut (
        .CLK(clk), .RST(rst), .CHIP_SELECT_N(cs_n), .SERIAL_CLK(sck), .SERIAL_IN(sdi),
        .SERIAL_OUT(sdo), .SERIAL_OUT_EN(sdo_en), .STANDBY_DISABLE_INPUT_N(inh_n),
        .LOGIC_SUPPLY_OK(lsup), .TEMP_WARN_HI(t_hi), .TEMP_WARN_LO(t_lo), .TEMP_SHUTDOWN(t_sd),
        .SUPPLY_OVERVOLT(ov), .SUPPLY_UNDERVOLT(uv), .OVERCURRENT(oc), .UNDERLOAD(ul),
        .GATE_SENSE(gate), .SWITCH_ON(sw), .CONTROL_WORD(ctl), .DIAGNOSTIC_STATUS_WORD(st));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_st;
        return m_fl[15:0] | {3'h0, gate, 1'b0};
    endfunction

    task automatic settle;
        repeat (8) @(negedge clk);
    endtask

    task automatic check_all;
        settle();
        chk(ctl, m_ctl[15:0]);
        chk(st, exp_st());
    endtask

    task automatic chk_sw(input logic [11:0] e);
        chk({4'h0, sw}, {4'h0, e});
    endtask

    // clear request takes effect at the frame after the one that set it
    task automatic send(input logic [15:0] wd);
        int en0;
        exp_q.push_back(exp_st());
        en0 = en_cycles;
        i_host.xfer(wd, rd);
        chk(rd, exp_q.pop_front());
        chk(16'(en_cycles - en0), 16'(FRAME_CYC));
        if (m_ctl[0])
            m_fl = 0;
        m_ctl = wd;
        check_all();
    endtask

    initial begin
        void'($urandom(32'hB910));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check_all();
        prev = 16'h0000;
        for (int k = 0; k < 5; k++) begin
            w = 16'($urandom) & 16'h9FFE;
            send(w);
            chk({4'h0, rd[12:1] ^ prev[12:1]}, 16'h0000);
            chk_sw(w[12:1]);
            gate = w[12:1];
            prev = w;
        end
        t_hi = 1'b1;
        settle();
        t_hi = 1'b0;
        m_fl |= 1;
        check_all();
        t_sd = 1'b1;
        settle();
        chk_sw(12'h000);
        check_all();
        t_sd = 1'b0;
        t_lo = 1'b1;
        settle();
        t_lo = 1'b0;
        m_fl &= ~1;
        check_all();
        send(16'h2002);
        oc = 12'h001;
        settle();
        chk_sw(12'h001);
        repeat (30) @(negedge clk);
        chk_sw(12'h000);
        oc = 12'h000;
        m_fl |= 1 << 13;
        check_all();
        send(16'h0002);
        oc = 12'h001;
        repeat (40) @(negedge clk);
        chk_sw(12'h001);
        oc = 12'h000;
        send(16'h0002);
        ul = 12'h004;
        settle();
        ul = 12'h000;
        check_all();
        repeat (60) @(negedge clk);
        ul = 12'h800;
        settle();
        ul = 12'h000;
        m_fl |= 1 << 14;
        check_all();
        ov = 1'b1;
        settle();
        chk_sw(12'h001);
        ov = 1'b0;
        m_fl |= 1 << 15;
        check_all();
        send(16'h0001);
        send(16'h0000);
        uv = 1'b1;
        settle();
        uv = 1'b0;
        m_fl |= 1 << 15;
        check_all();
        lsup = 1'b0;
        m_fl = 0;
        check_all();
        lsup = 1'b1;
        send(16'h0006);
        t_hi = 1'b1;
        settle();
        t_hi = 1'b0;
        inh_n = 1'b0;
        m_fl = 0;
        m_ctl = 0;
        check_all();
        chk_sw(12'h000);
        inh_n = 1'b1;
        settle();
        report_and_stop();
    end

    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
endmodule
